// ==== coupler_model.sv ====
`timescale 1ns/10ps
// Coupler end of the link: one-cycle frame strobes, prompt or with idle gaps
module coupler_model (
   input wire logic mclk,
   output logic link_out_valid = 1'b0,
   output logic [7:0] link_out_data = 8'h00,
   output logic link_param_valid = 1'b0,
   output logic [7:0] link_param_data = 8'h00
);
   // Must equal the node's switch setting, the link runs at one rate
   parameter bit LINK_250K = 1'b0;
   // Data is inverted after the strobe so a stale byte never reads as fresh
   task automatic send(input logic is_par, input logic [7:0] d, input int gap);
      @(posedge mclk);
      link_out_valid <= !is_par;
      link_param_valid <= is_par;
      link_out_data <= d;
      link_param_data <= d;
      @(posedge mclk);
      link_out_valid <= 1'b0;
      link_param_valid <= 1'b0;
      link_out_data <= ~d;
      link_param_data <= ~d;
      repeat (gap) @(posedge mclk);
   endtask
endmodule

// ==== fieldbus_digital_output_node.sv ====
`timescale 1ns/10ps
// Eight-channel output node: link-facing logic with a Wishbone view for the coupler side
module fieldbus_digital_output_node
   import node_pkg::*;
#(
   parameter int COMM_TIMEOUT = COMM_TIMEOUT_CYC,
   parameter int SETTLE = SETTLE_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link frame strobes from the link receiver
   input wire logic link_out_valid,
   input wire logic [7:0] link_out_data,
   input wire logic link_param_valid,
   input wire logic [7:0] link_param_data,
   // Switches and supervision inputs
   input wire logic [7:0] station_address_switch,
   input wire logic [1:0] rate_select_switch,
   input wire logic elec_supply_fault,
   input wire logic group_a_supply_fault,
   input wire logic group_b_supply_fault,
   input wire logic [7:0] short_det,
   input wire logic [7:0] open_det,
   // Outputs
   output logic [7:0] output_pin4,
   output logic [7:0] output_pin2,
   output logic [7:0] station_address,
   output logic auto_address,
   output logic rate_high,
   output logic [7:0] diag_byte_z,
   output logic [7:0] diag_byte_z1,
   output logic diag_changed
);
   node_state_t state_reg, state_next;
   logic [31:0] cnt_reg;
   logic [7:0] out_reg;
   logic [7:0] param_reg;
   logic [7:0] addr_reg;
   logic rate_reg;
   logic comm_lost_reg;
   logic [7:0] diag_z1_prev_reg;
   logic [7:0] diag_z_prev_reg;
   logic [7:0] fault;
   logic ack_reg;
   logic [31:0] rdata_reg;

   // Decode and selection
   wire logic wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire logic wb_wr = wb_req & wb_we_i & wb_sel_i[0];
   wire logic sel_out = (wb_adr_i == ADDR_OUT_DATA);
   wire logic sel_par = (wb_adr_i == ADDR_PARAM);
   wire logic sel_diag = (wb_adr_i == ADDR_DIAG);
   wire logic sel_stat = (wb_adr_i == ADDR_STATUS);
   wire logic out_load = (link_out_valid | (wb_wr & sel_out)) & (state_reg != ST_SETTLE);
   wire logic [7:0] out_src = link_out_valid ? link_out_data : wb_dat_i[7:0];
   wire logic par_load = link_param_valid | (wb_wr & sel_par);
   wire logic [7:0] par_src = link_param_valid ? link_param_data : wb_dat_i[7:0];
   wire logic timeout = (cnt_reg >= COMM_TIMEOUT - 1);
   wire logic settled = (cnt_reg >= SETTLE - 1);
   wire logic driving = (state_reg == ST_RUN) & ~comm_lost_reg;
   wire logic [7:0] drive = driving ? out_reg : OUT_RESET; // [R14]
   wire logic [7:0] z_now = {comm_lost_reg, 4'h0, group_b_supply_fault, group_a_supply_fault, elec_supply_fault};

   // Group A covers bits 0..3, group B bits 4..7; a failed supply group cannot drive
   wire logic [7:0] grp_ok = (group_a_supply_fault ? ~GROUP_A_MASK : 8'hFF)
                           & (group_b_supply_fault ? ~GROUP_B_MASK : 8'hFF); // [R3]

   // Sequencer: settle switches, wait for first data, run
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_SETTLE: if (settled) state_next = ST_WAIT_DATA;
         ST_WAIT_DATA: if (out_load) state_next = ST_RUN; // [R14]
         ST_RUN: state_next = ST_RUN;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_SETTLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // Shared counter: settle time first, then link silence watchdog
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 32'h0000_0000;
      end else if (ce) begin
         if (state_reg != ST_SETTLE && (link_out_valid || link_param_valid)) begin
            cnt_reg <= 32'h0000_0000;
         end else if (state_reg == ST_SETTLE && settled) begin
            cnt_reg <= 32'h0000_0000;
         end else if (!timeout) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
         end
      end
   end

   // Switches are captured once at the end of settling; later moves are ignored
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_reg <= 8'h00;
         rate_reg <= 1'b1;
      end else if (ce && state_reg == ST_SETTLE && settled) begin
         addr_reg <= station_address_switch; // [R4] [R7]
         rate_reg <= rate_select_switch[0]; // [R5]
      end
   end

   // Single output byte; link and software share it, link wins on a tie
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_reg <= OUT_RESET;
      end else if (ce && out_load) begin
         out_reg <= out_src; // [R1] [R8]
      end
   end

   // Parameter byte; reserved bits are kept at zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         param_reg <= PARAM_RESET;
      end else if (ce && par_load) begin
         param_reg <= par_src & PARAM_MASK; // [R2] [R13]
      end
   end

   // Communication loss flag: set by silence, cleared by the next frame
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         comm_lost_reg <= 1'b0;
      end else if (ce) begin
         // A frame in this very cycle ends the silence; counting it as a timeout would latch the flag
         if (state_reg != ST_SETTLE && timeout && !(link_out_valid || link_param_valid)) begin
            comm_lost_reg <= 1'b1; // [R12]
         end else if (link_out_valid || link_param_valid) begin
            comm_lost_reg <= 1'b0;
         end
      end
   end

   output_diag #(.WIDTH(NUM_OUT)) u_diag (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .drive(drive),
      .short_det(short_det),
      .open_det(open_det),
      .report_all(param_reg[PAR_REPORT_ALL]),
      .fault(fault)
   );

   // Outputs from flip-flops; pin 2 of each odd socket mirrors the next even output
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         output_pin4 <= 8'h00;
         output_pin2 <= 8'h00;
      end else if (ce) begin
         output_pin4 <= drive & grp_ok; // [R11] [R3]
         output_pin2 <= {1'b0, drive[7] & grp_ok[7], 1'b0, drive[5] & grp_ok[5],
                         1'b0, drive[3] & grp_ok[3], 1'b0, drive[1] & grp_ok[1]}; // [R11]
      end
   end

   // Diagnosis bytes returned instead of input data; change pulse for reporting
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         diag_byte_z <= 8'h00;
         diag_byte_z1 <= 8'h00;
         diag_z_prev_reg <= 8'h00;
         diag_z1_prev_reg <= 8'h00;
         diag_changed <= 1'b0;
      end else if (ce) begin
         diag_byte_z <= z_now; // [R12] [R10]
         diag_byte_z1 <= fault; // [R12]
         diag_z_prev_reg <= diag_byte_z;
         diag_z1_prev_reg <= diag_byte_z1;
         diag_changed <= (diag_byte_z != diag_z_prev_reg) | (diag_byte_z1 != diag_z1_prev_reg); // [R2]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         station_address <= 8'h00;
         auto_address <= 1'b0;
         rate_high <= 1'b1;
      end else if (ce) begin
         station_address <= addr_reg;
         auto_address <= (state_reg != ST_SETTLE) && (addr_reg == AUTO_ADDRESS); // [R9]
         rate_high <= rate_reg; // [R5]
      end
   end

   // Wishbone: one wait cycle, ack for one cycle, unmapped reads zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         ack_reg <= wb_req;
         if (wb_req) begin
            rdata_reg <= sel_out ? {24'h00_0000, out_reg} :
                         sel_par ? {24'h00_0000, param_reg} :
                         sel_diag ? {16'h0000, diag_byte_z1, diag_byte_z} :
                         sel_stat ? {16'h0000, addr_reg, 4'h0, comm_lost_reg, rate_reg, state_reg} :
                         32'h0000_0000;
         end
      end
   end
   assign wb_ack_o = ack_reg & wb_cyc_i & wb_stb_i;
   assign wb_dat_o = rdata_reg;
endmodule

// ==== node_pkg.sv ====
// Functional notes
// R1 - Eight outputs follow one output data byte received from the coupler.
// R2 - Accept one parameter byte; return two diagnosis bytes to the coupler.
// R3 - Outputs 1-4 belong to supply group A, outputs 5-8 to group B.
// R4 - Station address and rate switches are sampled only once after power-up.
// R5 - Rate switch bit 1: open 125 kBaud, on 250 kBaud; bit 2 unused.
// R6 - Every link participant must run at the same link rate.
// R7 - Station address fixes where the node's bytes sit in coupler data range.
// R8 - Node occupies exactly one byte of the controller output area.
// R9 - Address switch zero means take part in automatic address assignment.
// R10 - No input data; returned information sits in the diagnosis range only.
// R11 - Bit n drives output n+1; even outputs mirror onto preceding socket pin 2.
// R12 - Diag byte Z: comm lost, group B, group A, electronics; Z+1 per-output faults.
// R13 - Parameter bit 1: 0 report controlled outputs only, 1 report every change.
// R14 - Outputs stay inactive from reset until the first valid output byte arrives.
package node_pkg;
   localparam int NUM_OUT = 8;
   // Wishbone register byte addresses
   localparam logic [3:0] ADDR_OUT_DATA = 4'h0;
   localparam logic [3:0] ADDR_PARAM = 4'h4;
   localparam logic [3:0] ADDR_DIAG = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   // Diagnosis byte Z bit positions
   localparam int DZ_ELEC = 0;
   localparam int DZ_GRP_A = 1;
   localparam int DZ_GRP_B = 2;
   localparam int DZ_COMM = 7;
   // Parameter field
   localparam int PAR_REPORT_ALL = 1;
   localparam logic [7:0] PARAM_RESET = 8'h00;
   localparam logic [7:0] PARAM_MASK = 8'h02;
   localparam logic [7:0] OUT_RESET = 8'h00;
   // Output group split
   localparam logic [7:0] GROUP_A_MASK = 8'h0F;
   localparam logic [7:0] GROUP_B_MASK = 8'hF0;
   // Link rates
   localparam int RATE_LOW_KBAUD = 125;
   localparam int RATE_HIGH_KBAUD = 250;
   // Communication loss timeout and power-up switch settle time
   localparam int COMM_TIMEOUT_US = 10000;
   localparam int SETTLE_US = 100;
   localparam int CLK_MHZ = 10;
   localparam int COMM_TIMEOUT_CYC = COMM_TIMEOUT_US * CLK_MHZ;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   localparam logic [7:0] AUTO_ADDRESS = 8'h00;
   typedef enum logic [1:0] {ST_SETTLE, ST_WAIT_DATA, ST_RUN} node_state_t;
endpackage

// ==== node_sva.sv ====
`timescale 1ns/10ps
// Port-level checks; the age counter marks when switch capture must be over
module node_sva
   import node_pkg::*;
#(
   parameter int COMM_TIMEOUT = COMM_TIMEOUT_CYC,
   parameter int SETTLE = SETTLE_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic link_out_valid,
   input wire logic [7:0] link_out_data,
   input wire logic group_a_supply_fault,
   input wire logic group_b_supply_fault,
   input wire logic [7:0] output_pin4,
   input wire logic [7:0] output_pin2,
   input wire logic [7:0] station_address,
   input wire logic auto_address,
   input wire logic rate_high,
   input wire logic [7:0] diag_byte_z,
   input wire logic [7:0] diag_byte_z1,
   input wire logic diag_changed
);
   int up_cnt;
   logic live;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Saturates so a long run cannot wrap it back into the settle window
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         up_cnt <= 0;
      end else if (up_cnt <= SETTLE + 3) begin
         up_cnt <= up_cnt + 1;
      end
   end
   assign live = up_cnt > SETTLE + 3;
   chk_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
      else $error("no ack after request");
   chk_pin2_mirror: assert property (output_pin2 == ((output_pin4 >> 1) & 8'h55))
      else $error("pin 2 mirror wrong");
   chk_link_to_pin: assert property (live && link_out_valid && ce ##1 (!group_a_supply_fault &&
      !group_b_supply_fault && ce) [*2] |-> output_pin4 == $past(link_out_data, 2))
      else $error("output byte not driven");
   chk_auto_addr: assert property (live |-> auto_address == (station_address == 8'h00))
      else $error("auto address flag wrong");
   chk_switch_frozen: assert property (live |=> $stable(station_address) && $stable(rate_high))
      else $error("switch value moved while running");
   chk_grp_b_diag: assert property ((live && group_b_supply_fault) [*3] |-> diag_byte_z[DZ_GRP_B])
      else $error("group B fault not reported");
   chk_group_a_off: assert property ((live && group_a_supply_fault) [*3] |->
      (output_pin4 & GROUP_A_MASK) == 8'h00)
      else $error("group A driven without supply");
   chk_reserved_z: assert property (diag_byte_z[6:3] == 4'h0)
      else $error("unused diagnosis bits set");
   chk_diag_pulse: assert property ((!$stable(diag_byte_z) || !$stable(diag_byte_z1)) && ce |=> diag_changed)
      else $error("diagnosis change not flagged");
endmodule

bind fieldbus_digital_output_node node_sva #(.COMM_TIMEOUT(COMM_TIMEOUT), .SETTLE(SETTLE)) u_node_sva (
   .mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .link_out_valid, .link_out_data,
   .group_a_supply_fault, .group_b_supply_fault, .output_pin4, .output_pin2, .station_address,
   .auto_address, .rate_high, .diag_byte_z, .diag_byte_z1, .diag_changed);

// ==== output_diag.sv ====
`timescale 1ns/10ps
// Per-output fault qualification: short only while driven, open only while off
module output_diag
   import node_pkg::*;
#(
   parameter int WIDTH = NUM_OUT
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] drive,
   input wire logic [WIDTH-1:0] short_det,
   input wire logic [WIDTH-1:0] open_det,
   input wire logic report_all,
   output logic [WIDTH-1:0] fault
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_ch
         logic raw;
         // Controlled-only mode masks open reports on idle outputs
         assign raw = (drive[i] & short_det[i]) | (~drive[i] & open_det[i] & report_all); // [R13]
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               fault[i] <= 1'b0;
            end else if (ce) begin
               fault[i] <= raw; // [R12]
            end
         end
      end
   endgenerate
endmodule

// ==== test_fieldbus_digital_output_node.sv ====
`timescale 1ns/10ps
// Output node bench: coupler model on the link, Wishbone tasks for the register view
module test_fieldbus_digital_output_node
   import node_pkg::*;
;
   localparam int SET = 4;
   localparam int TMO = 50;
   logic mclk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic [7:0] station_address_switch = 8'h05, short_det = 8'h00, open_det = 8'h00;
   logic [1:0] rate_select_switch = 2'b10;
   logic elec_supply_fault = 1'b0, group_a_supply_fault = 1'b0, group_b_supply_fault = 1'b0;
   logic wb_ack_o, link_out_valid, link_param_valid, auto_address, rate_high;
   logic [7:0] link_out_data, link_param_data, output_pin4, output_pin2, station_address;
   logic [7:0] diag_byte_z, diag_byte_z1;
   logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h01};
   int fails = 0, total_checks = 0;
   fieldbus_digital_output_node #(.COMM_TIMEOUT(TMO), .SETTLE(SET)) i_dut (.mclk, .rst, .ce(1'b1),
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .link_out_valid, .link_out_data, .link_param_valid, .link_param_data, .station_address_switch,
      .rate_select_switch, .elec_supply_fault, .group_a_supply_fault, .group_b_supply_fault, .short_det,
      .open_det, .output_pin4, .output_pin2, .station_address, .auto_address, .rate_high, .diag_byte_z,
      .diag_byte_z1, .diag_changed());
   coupler_model i_cpl (.mclk, .link_out_valid, .link_out_data, .link_param_valid, .link_param_data);
   // 10 MHz clock
   initial begin
      forever #50 mclk = ~mclk;
   end
   // A stalled run ends here as a failure
   initial begin
      #2_000_000;
      fails++;
      report_and_stop();
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Settle on the falling edge so registered outputs have landed
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   // Classic cycle: hold everything until ack is sampled, read data taken at that edge
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      cyc_wait(1);
      check(output_pin4, OUT_RESET);
      check(rate_high, 1'b1);
      cyc_wait(SET + 4);
      @(posedge mclk) station_address_switch <= 8'h33;
      cyc_wait(2);
      check(station_address, 8'h05);
      check(rate_high, 1'b0);
      check(rate_high, i_cpl.LINK_250K);
      check(auto_address, 1'b0);
      wb(1'b0, ADDR_STATUS, 32'h0);
      check(rd, 32'h0000_0501);
      wb(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0000_0000);
      $display("test power-up done");
      foreach (pat[i]) begin
         i_cpl.send(1'b0, pat[i], i);
         cyc_wait(1);
         check(output_pin4, pat[i]);
         check(output_pin2, (pat[i] >> 1) & 8'h55);
         wb(1'b0, ADDR_OUT_DATA, 32'h0);
         check(rd, {24'h0, pat[i]});
      end
      wb(1'b1, ADDR_OUT_DATA, 32'h0000_00C3);
      cyc_wait(2);
      check(output_pin4, 8'hC3);
      $display("test output byte done");
      for (int k = 0; k < 3; k++) begin
         i_cpl.send(1'b0, 8'hFF, 0);
         @(posedge mclk) {group_b_supply_fault, group_a_supply_fault, elec_supply_fault} <= 3'b001 << k;
         cyc_wait(4);
         check(diag_byte_z, 8'h01 << k);
         check(output_pin4, k == 0 ? 8'hFF : (k == 1 ? GROUP_B_MASK : GROUP_A_MASK));
         @(posedge mclk) {group_b_supply_fault, group_a_supply_fault, elec_supply_fault} <= 3'b000;
      end
      $display("test supply faults done");
      i_cpl.send(1'b0, 8'h0F, 0);
      @(posedge mclk) short_det <= 8'hFF;
      cyc_wait(4);
      check(diag_byte_z1, 8'h0F);
      @(posedge mclk) short_det <= 8'h00;
      @(posedge mclk) open_det <= 8'hFF;
      cyc_wait(4);
      check(diag_byte_z1, 8'h00);
      i_cpl.send(1'b1, 8'hFF, 0);
      cyc_wait(4);
      check(diag_byte_z1, 8'hF0);
      wb(1'b0, ADDR_DIAG, 32'h0);
      check(rd, 32'h0000_F000);
      wb(1'b0, ADDR_PARAM, 32'h0);
      check(rd, 32'h0000_0002);
      wb(1'b1, ADDR_PARAM, 32'h0000_0000);
      cyc_wait(4);
      check(diag_byte_z1, 8'h00);
      $display("test diagnosis done");
      cyc_wait(TMO + 10);
      check(diag_byte_z, 8'h80);
      check(output_pin4, 8'h00);
      i_cpl.send(1'b0, 8'h3C, 0);
      cyc_wait(4);
      check(diag_byte_z, 8'h00);
      check(output_pin4, 8'h3C);
      $display("test link loss done");
      @(posedge mclk) rst <= 1'b1;
      @(posedge mclk) station_address_switch <= 8'h00;
      @(posedge mclk) rate_select_switch <= 2'b01;
      @(posedge mclk) rst <= 1'b0;
      cyc_wait(SET + 4);
      check(station_address, 8'h00);
      check(auto_address, 1'b1);
      check(rate_high, 1'b1);
      check(output_pin4, 8'h00);
      $display("test restart done");
      report_and_stop();
   end
endmodule
